// ### rcpb_buffer_engine.sv
// Message buffer pointer engine: split circular rings and A/B alternation.
`timescale 1ns/1ps

// Notes on behaviour
// - In split mode info ring length comes from control word bits 15..8.
// - Length codes FF..01 give 128..1 entries; offset field width follows the code.
// - The upper eight control word bits are never rewritten by the device.
// - Descriptor word two is the fixed data ring top, never written.
// - Descriptor word three is the live data address, readable by software.
// - Descriptor word four is base plus offset; only the offset is updated.
// - Each message writes info and time tag pair; after last entry wrap to top.
// - Every message starts by fetching all four descriptor words.
// - Receive data goes from current address upward; info pair written afterwards.
// - Transmit data fetched from current address; info pair written after completion.
// - At end, offset at last entry reloads data address to top, clears offset.
// - Split mode ignores index, notify, buffer-select and alternation enable bits.
// - Broadcast reception is reported in info word bit 5.
// - Info ring wrap raises full/empty interrupt when mask bit 8 and bit 7 allow.
// - With alternation on, active buffer chosen at start and bit 2 complemented.
// - Clearing enable stops alternation; acknowledge falls from one to zero.
// - Setting enable resumes alternation; acknowledge rises from zero to one.
// - Bit 2 zero selects buffer A, one selects buffer B; frozen keeps it.
// - While frozen, messages keep using the active buffer only.
module rcpb_buffer_engine
    import rcpb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        circModeBit7,
    input  wire logic        circModeBit8,
    input  wire logic        alternateBufferEnable,
    input  wire logic        fullEmptyMaskBit8,
    output logic             alternateBufferAck,
    input  wire logic        msgStart,
    input  wire logic [15:0] msgDescBase,
    input  wire logic        msgReceive,
    input  wire logic        msgBroadcast,
    output logic             msgBusy,
    output logic             wordReady,
    input  wire logic        rxWordValid,
    input  wire logic [15:0] rxWord,
    input  wire logic        txWordReq,
    output logic [15:0]      txWord,
    output logic             txWordValid,
    input  wire logic        msgEnd,
    input  wire logic        msgOk,
    input  wire logic [15:0] msgInfoWord,
    input  wire logic [15:0] msgTimeTag,
    output logic             memReq,
    output logic             memWrite,
    output logic [15:0]      memAddr,
    output logic [15:0]      memWdata,
    input  wire logic [15:0] memRdata,
    input  wire logic        memAck,
    output logic             messageIrqOut_n,
    output logic             activeBufferB
);

    rcpb_state_t state_q;
    rcpb_state_t state_d;

    logic [15:0] desc_q;
    logic [15:0] ctrl_q;
    logic [15:0] top_q;
    logic [15:0] cur_q;
    logic [15:0] ring_q;
    logic [15:0] ptr_q;
    logic [15:0] base_q;
    logic [15:0] rxData_q;
    logic [15:0] info_q;
    logic [15:0] tag_q;
    logic [15:0] txWord_q;
    logic        txValid_q;
    logic        ok_q;
    logic        bcast_q;
    logic        ppAck_q;
    logic        irq_q;

    // Length mask: the code itself is the offset mask in words.
    // Each ring entry is a pair of words, so a code of 03 covers two entries,
    // and offsets step by two inside the field that the mask selects.
    // An odd offset written by software is not repaired here; it would make
    // the last-pair test miss, so the ring would cycle through odd offsets and never wrap.
    function automatic logic [15:0] lenMask(input logic [15:0] ctrl);
        lenMask = {8'h00, ctrl[CTRL_LEN_MSB:CTRL_LEN_LSB]};
    endfunction

    // True when the ring offset holds the last pair of the ring.
    function automatic logic ringAtLast(input logic [15:0] ring, input logic [15:0] ctrl);
        ringAtLast = ((ring & lenMask(ctrl)) == (lenMask(ctrl) & ~WORD_STEP));
    endfunction

    // Next ring pointer: base field kept, only the offset field moves.
    function automatic logic [15:0] ringNext(input logic [15:0] ring, input logic [15:0] ctrl);
        if (ringAtLast(ring, ctrl))
        begin
            ringNext = ring & ~lenMask(ctrl);
        end
        else
        begin
            ringNext = (ring & ~lenMask(ctrl)) | ((ring + RING_PAIR_STEP) & lenMask(ctrl));
        end
    endfunction

    // Mode decode; in split mode the alternation enable is ignored.
    // The acknowledge, not the raw enable, gates alternation, so software
    // sees a freeze only after it is truly in force.
    wire splitMode   = circModeBit7 & circModeBit8;
    wire alternating = ppAck_q & ~splitMode;
    wire useBufB     = ctrl_q[CTRL_AB_BIT];
    wire accessSt    = (state_q != RCPB_IDLE) && (state_q != RCPB_XFER);
    wire step        = ce & memAck & accessSt;
    wire wrapNow     = splitMode & ringAtLast(ring_q, ctrl_q);
    wire [15:0] infoAddr = splitMode ? ring_q : base_q;
    wire [15:0] newCur   = wrapNow ? top_q : ptr_q;
    wire [15:0] newRing  = ringNext(ring_q, ctrl_q);
    wire [15:0] bufStart = useBufB ? cur_q : top_q;

    // Next state of the message sequencer.
    // Every memory access state waits for the acknowledge, so any number of
    // wait states in the shared memory only stretches the sequence.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            RCPB_IDLE:
                if (msgStart) state_d = RCPB_RD_CTRL;
            RCPB_RD_CTRL:
                if (memAck) state_d = RCPB_RD_TOP;
            RCPB_RD_TOP:
                if (memAck) state_d = RCPB_RD_CUR;
            RCPB_RD_CUR:
                if (memAck) state_d = RCPB_RD_RING;
            RCPB_RD_RING:
                if (memAck) state_d = alternating ? RCPB_WR_CTRL : RCPB_XFER;
            RCPB_WR_CTRL:
                if (memAck) state_d = RCPB_XFER;
            RCPB_XFER:
                if (msgEnd) state_d = RCPB_WR_INFO;
                else if (rxWordValid && msgReceive) state_d = RCPB_WR_DATA;
                else if (txWordReq && !msgReceive) state_d = RCPB_RD_DATA;
            RCPB_WR_DATA:
                if (memAck) state_d = RCPB_XFER;
            RCPB_RD_DATA:
                if (memAck) state_d = RCPB_XFER;
            RCPB_WR_INFO:
                if (memAck) state_d = RCPB_WR_TAG;
            RCPB_WR_TAG:
                if (memAck) state_d = (splitMode && ok_q) ? RCPB_WR_CUR : RCPB_IDLE;
            RCPB_WR_CUR:
                if (memAck) state_d = RCPB_WR_RING;
            RCPB_WR_RING:
                if (memAck) state_d = RCPB_IDLE;
            default:
                state_d = RCPB_IDLE;
        endcase
    end

    // Sequencer register.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= RCPB_IDLE;
        else if (ce)
            state_q <= state_d;
    end

    // Memory address select per access state.
    always_comb
    begin
        memAddr = WORD_RST;
        unique case (state_q)
            RCPB_RD_CTRL, RCPB_WR_CTRL: memAddr = desc_q + DESC_CTRL_OFS;
            RCPB_RD_TOP:                memAddr = desc_q + DESC_TOP_OFS;
            RCPB_RD_CUR, RCPB_WR_CUR:   memAddr = desc_q + DESC_CUR_OFS;
            RCPB_RD_RING, RCPB_WR_RING: memAddr = desc_q + DESC_RING_OFS;
            RCPB_WR_DATA, RCPB_RD_DATA: memAddr = ptr_q;
            RCPB_WR_INFO:               memAddr = infoAddr;
            RCPB_WR_TAG:                memAddr = infoAddr + INFO_TAG_OFS;
            default:                    memAddr = WORD_RST;
        endcase
    end

    // Write data select; the control write-back keeps the length byte as read.
    always_comb
    begin
        memWdata = WORD_RST;
        unique case (state_q)
            RCPB_WR_CTRL: memWdata = ctrl_q ^ (16'h0001 << CTRL_AB_BIT);
            RCPB_WR_DATA: memWdata = rxData_q;
            RCPB_WR_INFO: memWdata = info_q;
            RCPB_WR_TAG:  memWdata = tag_q;
            RCPB_WR_CUR:  memWdata = newCur;
            RCPB_WR_RING: memWdata = newRing;
            default:      memWdata = WORD_RST;
        endcase
    end

    // Top word is never a write target, so it stays fixed in memory.
    assign memReq   = accessSt;
    assign memWrite = (state_q == RCPB_WR_CTRL) || (state_q == RCPB_WR_DATA) ||
                      (state_q == RCPB_WR_INFO) || (state_q == RCPB_WR_TAG) ||
                      (state_q == RCPB_WR_CUR) || (state_q == RCPB_WR_RING);
    assign wordReady = (state_q == RCPB_XFER);
    assign msgBusy   = (state_q != RCPB_IDLE);

    // Message context latched at start.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            desc_q  <= WORD_RST;
            bcast_q <= 1'b0;
        end
        else if (ce && state_q == RCPB_IDLE && msgStart)
        begin
            desc_q  <= msgDescBase;
            bcast_q <= msgBroadcast;
        end
    end

    // Descriptor words captured as they are read.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q <= WORD_RST;
            top_q  <= WORD_RST;
            cur_q  <= WORD_RST;
            ring_q <= WORD_RST;
        end
        else if (step)
        begin
            if (state_q == RCPB_RD_CTRL) ctrl_q <= memRdata;
            if (state_q == RCPB_RD_TOP)  top_q  <= memRdata;
            if (state_q == RCPB_RD_CUR)  cur_q  <= memRdata;
            if (state_q == RCPB_RD_RING) ring_q <= memRdata;
        end
    end

    // Buffer start for the info pair in the non-split mode, set on entering transfer.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            base_q <= WORD_RST;
        else if (step && state_d == RCPB_XFER &&
                 (state_q == RCPB_RD_RING || state_q == RCPB_WR_CTRL))
            base_q <= bufStart;
    end

    // Working data address: starts at the current address, one step per word.
    // In the alternate-buffer mode the first two words of a buffer are kept
    // for the information pair, so data starts two words in.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ptr_q <= WORD_RST;
        else if (step && state_d == RCPB_XFER &&
                 (state_q == RCPB_RD_RING || state_q == RCPB_WR_CTRL))
            ptr_q <= splitMode ? cur_q : bufStart + BUF_DATA_OFS;
        else if (step && (state_q == RCPB_WR_DATA || state_q == RCPB_RD_DATA))
            ptr_q <= ptr_q + WORD_STEP;
    end

    // Received word held for the memory write.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rxData_q <= WORD_RST;
        else if (ce && state_q == RCPB_XFER && rxWordValid && msgReceive && !msgEnd)
            rxData_q <= rxWord;
    end

    // End-of-message status; the info pair goes out only after the data phase.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            info_q <= WORD_RST;
            tag_q  <= WORD_RST;
            ok_q   <= 1'b0;
        end
        else if (ce && state_q == RCPB_XFER && msgEnd)
        begin
            info_q <= msgInfoWord | ({15'h0000, bcast_q} << INFO_BCAST_BIT);
            tag_q  <= msgTimeTag;
            ok_q   <= msgOk;
        end
    end

    // Fetched transmit word, presented with a one-cycle valid.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            txWord_q  <= WORD_RST;
            txValid_q <= 1'b0;
        end
        else if (ce)
        begin
            txValid_q <= step && state_q == RCPB_RD_DATA;
            if (step && state_q == RCPB_RD_DATA)
                txWord_q <= memRdata;
        end
    end

    // The acknowledge follows the enable only between messages, so a frozen
    // state is truly in force once the acknowledge has fallen.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ppAck_q <= 1'b0;
        else if (ce && state_q == RCPB_IDLE && !msgStart)
            ppAck_q <= alternateBufferEnable;
    end

    // Full/empty event on a ring wrap, gated by mask and control word bit 7.
    // It is raised only on the ring write-back, so a message that ends in
    // error and keeps its pointers also raises no event.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irq_q <= 1'b0;
        else if (ce)
            irq_q <= step && state_q == RCPB_WR_RING && wrapNow &&
                     fullEmptyMaskBit8 && ctrl_q[CTRL_FE_EN_BIT];
    end

    // Outputs; the interrupt pin is active low for one cycle.
    assign alternateBufferAck = ppAck_q;
    assign txWord             = txWord_q;
    assign txWordValid        = txValid_q;
    assign messageIrqOut_n    = ~irq_q;
    assign activeBufferB      = useBufB;

endmodule

// ### rcpb_pkg.sv
// Constants and types shared by the ring and alternate-buffer engine.
package rcpb_pkg;

    // Descriptor word offsets from the descriptor base address.
    localparam logic [15:0] DESC_CTRL_OFS = 16'h0000;
    localparam logic [15:0] DESC_TOP_OFS  = 16'h0001;
    localparam logic [15:0] DESC_CUR_OFS  = 16'h0002;
    localparam logic [15:0] DESC_RING_OFS = 16'h0003;

    // Descriptor control word fields.
    localparam int CTRL_LEN_MSB   = 15;
    localparam int CTRL_LEN_LSB   = 8;
    localparam int CTRL_FE_EN_BIT = 7;
    localparam int CTRL_AB_BIT    = 2;

    // Message information word broadcast_flag position.
    localparam int INFO_BCAST_BIT = 5;

    // Buffer layout in the non-split mode: info, time tag, then data.
    localparam logic [15:0] INFO_TAG_OFS   = 16'h0001;
    localparam logic [15:0] BUF_DATA_OFS   = 16'h0002;
    localparam logic [15:0] RING_PAIR_STEP = 16'h0002;
    localparam logic [15:0] WORD_STEP      = 16'h0001;

    // Reset values.
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [3:0] {
        RCPB_IDLE,
        RCPB_RD_CTRL,
        RCPB_RD_TOP,
        RCPB_RD_CUR,
        RCPB_RD_RING,
        RCPB_WR_CTRL,
        RCPB_XFER,
        RCPB_WR_DATA,
        RCPB_RD_DATA,
        RCPB_WR_INFO,
        RCPB_WR_TAG,
        RCPB_WR_CUR,
        RCPB_WR_RING
    } rcpb_state_t;

endpackage

// ### rcpb_mem_model.sv
// Shared-memory model on the far side of the engine's access port.
`timescale 1ns/1ps
module rcpb_mem_model
(
    input  wire logic        clk_sys,
    input  wire logic        ce,
    input  wire logic [1:0]  waitCycles,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWdata,
    output logic [15:0]      memRdata,
    output logic             memAck
);
    logic [15:0] mem [0:255];
    logic [1:0]  waitQ = 2'h0;
    logic [15:0] noiseQ = 16'h5a5a;
    // Only read data that is being acknowledged is valid; otherwise the lines churn.
    assign memAck   = memReq && (waitQ == waitCycles);
    assign memRdata = (memAck && !memWrite) ? mem[memAddr[7:0]] : noiseQ;
    // Each access waits afresh, so a slow setting delays every word.
    always @(posedge clk_sys)
    begin
        noiseQ <= ~noiseQ ^ {noiseQ[14:0], 1'b1};
        if (ce && memAck)
        begin
            waitQ <= 2'h0;
            if (memWrite)
                mem[memAddr[7:0]] <= memWdata;
        end
        else if (ce && memReq)
            waitQ <= waitQ + 2'h1;
    end
endmodule

// ### rcpb_buffer_engine_assertions.sv
// Concurrent checks on the buffer engine's ports.
`timescale 1ns/1ps
module rcpb_buffer_engine_assertions
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        circModeBit7,
    input wire logic        circModeBit8,
    input wire logic        alternateBufferEnable,
    input wire logic        fullEmptyMaskBit8,
    input wire logic        alternateBufferAck,
    input wire logic        msgStart,
    input wire logic [15:0] msgDescBase,
    input wire logic        msgBusy,
    input wire logic        txWordValid,
    input wire logic [15:0] txWord,
    input wire logic        memReq,
    input wire logic        memWrite,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic [15:0] memRdata,
    input wire logic        memAck,
    input wire logic        messageIrqOut_n
);
    logic [15:0] descQ;
    logic [15:0] ctrlQ;
    wire         accDone = memReq && memAck && ce;
    wire         startTaken = msgStart && !msgBusy && ce;
    wire         splitMode = circModeBit7 && circModeBit8;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Remember the descriptor and its control word so write-backs can be judged.
    always_ff @(posedge clk_sys)
    begin
        if (startTaken)
            descQ <= msgDescBase;
        if (accDone && !memWrite && memAddr == descQ)
            ctrlQ <= memRdata;
    end
    property p_reset_quiet; disable iff (1'b0) rst |=> !msgBusy && !memReq && !txWordValid && messageIrqOut_n && !alternateBufferAck; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
    property p_fetch_first; startTaken |=> msgBusy && memReq && !memWrite && memAddr == $past(msgDescBase); endproperty
    a_fetch_first: assert property (p_fetch_first) else $error("descriptor fetch missing");
    property p_ack_follow; !msgBusy && !msgStart && ce |=> alternateBufferAck == $past(alternateBufferEnable); endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("acknowledge did not follow");
    property p_ack_frozen; msgBusy |=> $stable(alternateBufferAck); endproperty
    a_ack_frozen: assert property (p_ack_frozen) else $error("acknowledge moved mid-message");
    property p_ctrl_write; memReq && memWrite && memAddr == descQ |-> !splitMode && memWdata == (ctrlQ ^ 16'h0004); endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("bad control word write");
    property p_top_static; memReq && memWrite |-> memAddr != descQ + 16'h0001; endproperty
    a_top_static: assert property (p_top_static) else $error("ring top word written");
    property p_tx_data; txWordValid |-> $past(accDone && !memWrite) && txWord == $past(memRdata); endproperty
    a_tx_data: assert property (p_tx_data) else $error("transmit word not from memory");
    property p_irq_pulse; !messageIrqOut_n |=> messageIrqOut_n; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq held low");
    property p_irq_cause; $fell(messageIrqOut_n) |-> fullEmptyMaskBit8 && splitMode && ctrlQ[7]; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq while masked");
endmodule
bind rcpb_buffer_engine rcpb_buffer_engine_assertions u_chk (.clk_sys, .rst, .ce, .circModeBit7,
    .circModeBit8, .alternateBufferEnable, .fullEmptyMaskBit8, .alternateBufferAck, .msgStart,
    .msgDescBase, .msgBusy, .txWordValid, .txWord, .memReq, .memWrite, .memAddr, .memWdata,
    .memRdata, .memAck, .messageIrqOut_n);

// ### rcpb_buffer_engine_tb_top.sv
// Bench: split rings with wrap, transmit fetch, A/B alternation and freeze.
`timescale 1ns/1ps
module rcpb_buffer_engine_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        splitMode = 1'b1;
    logic        altEn = 1'b1;
    logic        maskBit = 1'b1;
    logic        msgStart = 1'b0;
    logic [15:0] msgDescBase = 16'h0000;
    logic        msgReceive = 1'b0;
    logic        msgBroadcast = 1'b0;
    logic        rxWordValid = 1'b0;
    logic [15:0] rxWord = 16'h0000;
    logic        txWordReq = 1'b0;
    logic        msgEnd = 1'b0;
    logic [15:0] msgTimeTag = 16'h0000;
    logic [1:0]  waitCycles = 2'h0;
    logic        alternateBufferAck, msgBusy, wordReady, txWordValid, memReq, memWrite, memAck;
    logic        messageIrqOut_n, activeBufferB;
    logic [15:0] txWord, memAddr, memWdata, memRdata;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          irqSeen = 0;
    rcpb_buffer_engine dut (.clk_sys, .rst, .ce, .circModeBit7(splitMode),
        .circModeBit8(splitMode), .alternateBufferEnable(altEn), .fullEmptyMaskBit8(maskBit),
        .alternateBufferAck, .msgStart, .msgDescBase, .msgReceive, .msgBroadcast, .msgBusy,
        .wordReady, .rxWordValid, .rxWord, .txWordReq, .txWord, .txWordValid, .msgEnd,
        .msgOk(1'b1), .msgInfoWord(16'h1100), .msgTimeTag, .memReq, .memWrite, .memAddr,
        .memWdata, .memRdata, .memAck, .messageIrqOut_n, .activeBufferB);
    rcpb_mem_model mem (.clk_sys, .ce, .waitCycles, .memReq, .memWrite, .memAddr, .memWdata,
        .memRdata, .memAck);
    always #50 clk_sys = ~clk_sys;
    // Count irq pulses away from the launching edge; a hang ends the run.
    always @(negedge clk_sys)
    begin
        cyc++;
        if (messageIrqOut_n === 1'b0)
            irqSeen++;
        if (cyc == 5000)
        begin
            err_count++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitFor(ref logic sig, input logic lvl);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (sig !== lvl && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    // One message as the bus side sees it; word and end strobes wait for wordReady, and all strobes last one cycle.
    task automatic runMsg(input logic [15:0] desc, input logic rx, input logic bc, input int n,
                          input logic [15:0] first, input logic [15:0] tag);
        msgDescBase = desc;
        msgReceive = rx;
        msgBroadcast = bc;
        msgTimeTag = tag;
        msgStart = 1'b1;
        @(negedge clk_sys);
        msgStart = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            waitFor(wordReady, 1'b1);
            rxWord = first + 16'(i);
            rxWordValid = rx;
            txWordReq = !rx;
            @(negedge clk_sys);
            rxWordValid = 1'b0;
            txWordReq = 1'b0;
            if (!rx)
            begin
                if (txWordValid !== 1'b1)
                    waitFor(txWordValid, 1'b1);
                check(txWord, first + 16'(i));
            end
        end
        waitFor(wordReady, 1'b1);
        msgEnd = 1'b1;
        @(negedge clk_sys);
        msgEnd = 1'b0;
        waitFor(msgBusy, 1'b0);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic splitScenario();
        check(16'(alternateBufferAck), 16'h1);
        runMsg(16'h0010, 1'b1, 1'b1, 2, 16'ha000, 16'h7001);
        check(mem.mem[8'h81], 16'ha001);
        check(mem.mem[8'h40], 16'h1120);
        check(mem.mem[8'h41], 16'h7001);
        check(mem.mem[8'h12], 16'h0082);
        check(mem.mem[8'h13], 16'h0042);
        runMsg(16'h0010, 1'b1, 1'b0, 1, 16'hb000, 16'h7002);
        check(mem.mem[8'h43], 16'h7002);
        check(mem.mem[8'h12], 16'h0080);
        check(mem.mem[8'h13], 16'h0040);
        check(16'(irqSeen), 16'h1);
        waitCycles = 2'h2;
        runMsg(16'h0010, 1'b0, 1'b0, 2, 16'ha000, 16'h7003);
        check(mem.mem[8'h41], 16'h7003);
        check(mem.mem[8'h12], 16'h0082);
        maskBit = 1'b0;
        runMsg(16'h0010, 1'b0, 1'b0, 1, 16'hb000, 16'h7004);
        check(mem.mem[8'h12], 16'h0080);
        check(16'(irqSeen), 16'h1);
        check(mem.mem[8'h10], 16'h0380);
        check(mem.mem[8'h11], 16'h0080);
    endtask
    // Software sequence: alternate, freeze, service, re-enable.
    task automatic abScenario();
        splitMode = 1'b0;
        runMsg(16'h0020, 1'b1, 1'b0, 1, 16'hc000, 16'h7101);
        check({activeBufferB, mem.mem[8'ha2]}, {1'b0, 16'hc000});
        check(mem.mem[8'h20], 16'h5504);
        runMsg(16'h0020, 1'b1, 1'b0, 1, 16'hc100, 16'h7102);
        check({activeBufferB, mem.mem[8'hc2]}, {1'b1, 16'hc100});
        altEn = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(16'(alternateBufferAck), 16'h0);
        runMsg(16'h0020, 1'b1, 1'b0, 1, 16'hc200, 16'h7103);
        check(mem.mem[8'h20], 16'h5500);
        runMsg(16'h0020, 1'b1, 1'b0, 1, 16'hc300, 16'h7104);
        check({mem.mem[8'ha2], mem.mem[8'hc2]}, {16'hc300, 16'hc100});
        ce = 1'b0;
        altEn = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(16'(alternateBufferAck), 16'h0);
        ce = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(16'(alternateBufferAck), 16'h1);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Descriptors: split ring of two entries, then an A/B pair with buffers at a0 and c0.
    initial
    begin
        mem.mem[8'h10] = 16'h0380;
        mem.mem[8'h11] = 16'h0080;
        mem.mem[8'h12] = 16'h0080;
        mem.mem[8'h13] = 16'h0040;
        mem.mem[8'h20] = 16'h5500;
        mem.mem[8'h21] = 16'h00a0;
        mem.mem[8'h22] = 16'h00c0;
        mem.mem[8'h23] = 16'h0000;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        splitScenario();
        abScenario();
        final_report();
    end
endmodule
